// file: inc/tws_regs.svh
// Constants of the two-wire memory slave: space sizes, page masks, status codes and write timing.
// Included by bare name by every design file that needs a figure.
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
`define TWS_ARR_BYTES     512
`define TWS_CCR_BYTES     64
`define TWS_CCR_PAGE      8
`define TWS_PAGE_LANES    64
`define TWS_ARR_MASK      16'h01FF
`define TWS_CCR_MASK      16'h003F
`define TWS_ARR_PG_MASK   16'h003F
`define TWS_CCR_PG_MASK   16'h0007
`define TWS_RST_ADDR      16'h0000
`define TWS_SR_ADDR       16'h003F
`define TWS_SR_CLEAR      8'h00
`define TWS_SR_SET_WEL    8'h02
`define TWS_SR_SET_BOTH   8'h06
`define TWS_NVW_TIME_MS   5
`define TWS_CLK_SYS_MHZ   100
`endif

// file: inc/tws_pkg.sv
// Types shared by the two-wire memory slave.
// Assumes nothing of its surroundings.
package tws_pkg;
   typedef enum logic [2:0] {S_IDLE, S_SLAVE, S_WAHI, S_WALO, S_WDATA, S_RDATA, S_IGNORE} tws_state_e;
   typedef logic [15:0] tws_addr_t;
endpackage

// file: inc/tws_link_if.sv
// Signals between the pin synchroniser, the serial engine and the write timer.
// Pin side signals live on the link clock; the toggles cross between the domains.
`timescale 1ns/10ps
interface tws_link_if;
   logic       sda_v;
   logic       start;
   logic       stop;
   logic       rise;
   logic       fall;
   logic       rst_n_l;
   logic       done_s;
   logic [1:0] prot;
   logic       req_tgl;
   logic       done_tgl;
   modport fe   (output sda_v, start, stop, rise, fall, rst_n_l, done_s, prot, input done_tgl);
   modport core (input sda_v, start, stop, rise, fall, rst_n_l, done_s, prot, output req_tgl);
   modport tmr  (input req_tgl, output done_tgl);
endinterface

// file: rtl/tws_pin_sync.sv
// Pin and level synchroniser on the link clock, with start, stop and clock edge detection.
// Assumes the serial pins, the reset, the protection select and the done toggle are asynchronous to it.
`timescale 1ns/10ps
module tws_pin_sync (
   // Clock
   input  wire logic       link_clk,
   // Raw levels
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       rst_n,
   input  wire logic [1:0] prot,
   // Engine side
   tws_link_if.fe          lnk
);
   localparam int W = 6;
   logic [W-1:0] din;
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic         scl_p_q;
   logic         sda_p_q;
   logic         scl_s;
   logic         sda_s;

   assign din = {prot, lnk.done_tgl, rst_n, sda, scl};

   // The first stage is read only by the second one.
   generate
      for (genvar i = 0; i < W; i++) begin : g_sync
         always_ff @(posedge link_clk) begin
            s1_q[i] <= din[i];
            s2_q[i] <= s1_q[i];
         end
      end
   endgenerate

   always_ff @(posedge link_clk) begin
      scl_p_q <= s2_q[0];
      sda_p_q <= s2_q[1];
   end

   assign scl_s       = s2_q[0];
   assign sda_s       = s2_q[1];
   assign lnk.rst_n_l = s2_q[2];
   assign lnk.done_s  = s2_q[3];
   assign lnk.prot    = s2_q[5:4];
   assign lnk.sda_v   = sda_s;
   assign lnk.rise    = scl_s & ~scl_p_q;
   assign lnk.fall    = ~scl_s & scl_p_q;
   assign lnk.start   = scl_s & scl_p_q & ~sda_s & sda_p_q;
   assign lnk.stop    = scl_s & scl_p_q & sda_s & ~sda_p_q;
endmodule // tws_pin_sync

// file: rtl/tws_nvw_timer.sv
// Nonvolatile write busy timer on the system clock, started and answered by toggles.
// Assumes the request toggle comes from the link clock domain.
`timescale 1ns/10ps
`include "tws_regs.svh"
module tws_nvw_timer #(
   parameter int NVW_CYCLES = `TWS_NVW_TIME_MS * 1000 * `TWS_CLK_SYS_MHZ
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // Status
   output logic      busy,
   // Link side
   tws_link_if.tmr   lnk
);
   logic        r1_q;
   logic        r2_q;
   logic        r3_q;
   logic        r3_d;
   logic        busy_q;
   logic        busy_d;
   logic        done_q;
   logic        done_d;
   logic [23:0] cnt_q;
   logic [23:0] cnt_d;

   always_ff @(posedge clk_sys) begin
      r1_q <= lnk.req_tgl;
      r2_q <= r1_q;
   end

   always_comb begin
      r3_d   = r2_q;
      busy_d = busy_q;
      done_d = done_q;
      cnt_d  = cnt_q;
      if (busy_q) begin
         if (cnt_q == 24'(NVW_CYCLES - 1)) begin
            busy_d = 1'b0;
            done_d = ~done_q;
         end else begin
            cnt_d = cnt_q + 24'h000001;
         end
      end else if (r2_q != r3_q) begin
         busy_d = 1'b1;
         cnt_d  = 24'h000000;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         r3_q   <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         cnt_q  <= 24'h000000;
      end else begin
         r3_q   <= r3_d;
         busy_q <= busy_d;
         done_q <= done_d;
         cnt_q  <= cnt_d;
      end
   end

   assign busy         = busy_q;
   assign lnk.done_tgl = done_q;
endmodule // tws_nvw_timer

// file: rtl/tws_eeprom_slave.sv
// Two-wire slave giving byte access to a 512-byte nonvolatile array and a clock/control space.
// Assumes an external bus master drives SCL and an open-drain SDA wire resolved outside.
`timescale 1ns/10ps
`include "tws_regs.svh"
// What this block does
// - Transmitter releases data after eight bits; receiver pulls low on ninth clock.
// - Slave byte with wrong identifier or select is not acknowledged, rest ignored.
// - Write data bytes, except the status register byte, are not acknowledged while the write enable latch is clear.
// - Status register write takes one byte; a second byte gets no acknowledge.
// - Reads send eight bits, check master acknowledge, continue or stop sending.
// - Upper four slave bits choose the array or the clock/control space.
// - Slave bits 3..1 must match the select value; bit 0 is read/write.
// - Writes and random reads carry two acknowledged word address bytes.
// - Sixteen-bit address counter starts at zero, then holds last byte read or written plus one, wrapped within the page after writes.
// - Stop after acknowledged data starts the write; bus ignored while busy.
// - Protected writes are acknowledged but start no internal write cycle.
// - Page writes take 64 or 8 bytes, address wrapping within the page.
// - Bytes beyond a page overwrite earlier bytes at the wrapped location.
// - Stop before a full acknowledged byte or mid byte aborts with no write.
// - Array slave byte is refused while busy and acknowledged after completion.
// - Random read: write slave byte, address bytes, repeated start, read slave byte.
// - Stop after the address bytes loads the counter and returns to standby.
// - Sequential reads run through the whole space and wrap to address zero.
// - Status write 02h sets WEL; 06h sets the register latch only while WEL is set; 00h clears both.
// - A clock/control write clears the register write enable latch at the stop that starts it.
module tws_eeprom_slave #(
   parameter int         NVW_CYCLES = `TWS_NVW_TIME_MS * 1000 * `TWS_CLK_SYS_MHZ,
   parameter logic [3:0] ID_ARRAY   = 4'h5,  // Arbitrary value.
   parameter logic [3:0] ID_CTRL    = 4'h6,  // Arbitrary value.
   parameter logic [2:0] DEV_SEL    = 3'h2   // Arbitrary value.
) (
   // Clocks and reset
   input  wire logic       CLK_SYS,
   input  wire logic       RST_N,
   input  wire logic       LINK_CLK,
   // Serial pins
   input  wire logic       SCL,
   input  wire logic       SDA_I,
   output logic            SDA_O,
   output logic            SDA_OE,
   // Configuration
   input  wire logic [1:0] PROTECT_SEL,
   // Status
   output logic            NVW_BUSY,
   output logic            WRITE_ENABLE_LATCH,
   output logic            REGISTER_WRITE_ENABLE_LATCH
);
   tws_link_if lnk ();

   tws_pin_sync u_sync (
      .link_clk (LINK_CLK),
      .scl      (SCL),
      .sda      (SDA_I),
      .rst_n    (RST_N),
      .prot     (PROTECT_SEL),
      .lnk      (lnk.fe)
   );

   tws_nvw_timer #(.NVW_CYCLES(NVW_CYCLES)) u_timer (
      .clk_sys (CLK_SYS),
      .rst_n   (RST_N),
      .busy    (NVW_BUSY),
      .lnk     (lnk.tmr)
   );

   tws_pkg::tws_state_e st_q, st_d;
   logic [3:0]          bit_q, bit_d;
   logic [7:0]          sh_q, sh_d;
   logic                ack_q, ack_d;
   logic                mack_q, mack_d;
   logic                oe_q, oe_d;
   logic                ccr_q, ccr_d;
   logic                sr_q, sr_d;
   logic [7:0]          srv_q, srv_d;
   logic [7:0]          whi_q, whi_d;
   tws_pkg::tws_addr_t  addr_q, addr_d;
   logic [6:0]          cnt_q, cnt_d;
   logic [63:0]         pval_q, pval_d;
   logic                wel_q, wel_d;
   logic                register_write_enable_latch_q, register_write_enable_latch_d;
   logic                req_q, req_d;
   logic                busy_l;
   logic                buf_we;
   logic                commit;
   logic                prot_hit;
   logic [5:0]          lane;
   logic [7:0]          rd_byte;
   logic [7:0]          arr_mem [0:`TWS_ARR_BYTES-1];
   logic [7:0]          ccr_mem [0:`TWS_CCR_BYTES-1];
   logic [7:0]          pbuf    [0:`TWS_PAGE_LANES-1];

   // Next address: within the page for writes, across the whole space for reads.
   function automatic tws_pkg::tws_addr_t nxt(input tws_pkg::tws_addr_t a, input logic c, input logic pg);
      tws_pkg::tws_addr_t m;
      m = pg ? (c ? `TWS_CCR_PG_MASK : `TWS_ARR_PG_MASK) : (c ? `TWS_CCR_MASK : `TWS_ARR_MASK);
      nxt = pg ? ((a & ~m) | ((a + 16'h0001) & m)) : ((a + 16'h0001) & m);
   endfunction

   // Protected array region grows from the top: none, upper quarter, upper half, all.
   always_comb begin
      case (lnk.prot)
         2'h1:    prot_hit = (addr_q[8:7] == 2'h3);
         2'h2:    prot_hit = addr_q[8];
         2'h3:    prot_hit = 1'b1;
         default: prot_hit = 1'b0;
      endcase
   end

   assign busy_l = req_q ^ lnk.done_s;
   assign lane   = ccr_q ? {3'h0, addr_q[2:0]} : addr_q[5:0];

   always_comb begin
      if (ccr_q && addr_q == `TWS_SR_ADDR) begin
         rd_byte = {5'h00, register_write_enable_latch_q, wel_q, 1'b0};
      end else if (ccr_q) begin
         rd_byte = ccr_mem[addr_q[5:0]];
      end else begin
         rd_byte = arr_mem[addr_q[8:0]];
      end
   end

   always_comb begin
      st_d   = st_q;
      bit_d  = bit_q;
      sh_d   = sh_q;
      ack_d  = ack_q;
      mack_d = mack_q;
      oe_d   = oe_q;
      ccr_d  = ccr_q;
      sr_d   = sr_q;
      srv_d  = srv_q;
      whi_d  = whi_q;
      addr_d = addr_q;
      cnt_d  = cnt_q;
      pval_d = pval_q;
      wel_d  = wel_q;
      register_write_enable_latch_d = register_write_enable_latch_q;
      req_d  = req_q;
      buf_we = 1'b0;
      commit = 1'b0;
      if (busy_l) begin
         // While the array is being written nothing on the bus is answered.
         st_d  = tws_pkg::S_IDLE;
         oe_d  = 1'b0;
         ack_d = 1'b0;
      end else if (lnk.start) begin
         st_d   = tws_pkg::S_SLAVE;
         bit_d  = 4'h0;
         ack_d  = 1'b0;
         oe_d   = 1'b0;
         cnt_d  = 7'h00;
         pval_d = 64'h0;
         sr_d   = 1'b0;
      end else if (lnk.stop) begin
         st_d  = tws_pkg::S_IDLE;
         oe_d  = 1'b0;
         ack_d = 1'b0;
         bit_d = 4'h0;
         // The clock rise that carries a stop is already counted as the first bit of a next byte.
         if (st_q == tws_pkg::S_WDATA && cnt_q != 7'h00 && bit_q <= 4'h1 && !ack_q) begin
            if (sr_q) begin
               // Latch updates are volatile and take no busy time.
               case (srv_q)
                  `TWS_SR_CLEAR: begin
                     wel_d  = 1'b0;
                     register_write_enable_latch_d = 1'b0;
                  end
                  `TWS_SR_SET_WEL: wel_d = 1'b1;
                  `TWS_SR_SET_BOTH: begin
                     if (wel_q) begin
                        register_write_enable_latch_d = 1'b1;
                     end
                  end
                  default: wel_d = wel_q;
               endcase
            end else if (ccr_q ? register_write_enable_latch_q : !prot_hit) begin
               commit = 1'b1;
               req_d  = ~req_q;
               if (ccr_q) begin
                  register_write_enable_latch_d = 1'b0;
               end
            end
         end
      end else if (lnk.rise && !ack_q && bit_q < 4'h8 && (st_q == tws_pkg::S_SLAVE || st_q == tws_pkg::S_WAHI
                   || st_q == tws_pkg::S_WALO || st_q == tws_pkg::S_WDATA)) begin
         sh_d  = {sh_q[6:0], lnk.sda_v};
         bit_d = bit_q + 4'h1;
      end else if (lnk.rise && st_q == tws_pkg::S_RDATA && bit_q == 4'h9) begin
         mack_d = ~lnk.sda_v;
         addr_d = nxt(addr_q, ccr_q, 1'b0);
      end else if (lnk.fall) begin
         if (ack_q) begin
            // End of the ninth clock: release the line, or in a read drive the first data bit.
            ack_d = 1'b0;
            oe_d  = 1'b0;
            bit_d = 4'h0;
            if (st_q == tws_pkg::S_RDATA) begin
               sh_d  = {rd_byte[6:0], 1'b0};
               oe_d  = ~rd_byte[7];
               bit_d = 4'h1;
            end
         end else if (st_q == tws_pkg::S_RDATA) begin
            if (bit_q < 4'h8) begin
               oe_d  = ~sh_q[7];
               sh_d  = {sh_q[6:0], 1'b0};
               bit_d = bit_q + 4'h1;
            end else if (bit_q == 4'h8) begin
               oe_d  = 1'b0;
               bit_d = 4'h9;
            end else if (mack_q) begin
               sh_d  = {rd_byte[6:0], 1'b0};
               oe_d  = ~rd_byte[7];
               bit_d = 4'h1;
            end else begin
               st_d = tws_pkg::S_IGNORE;
               oe_d = 1'b0;
            end
         end else if (bit_q == 4'h8) begin
            ack_d = 1'b1;
            case (st_q)
               tws_pkg::S_SLAVE: begin
                  if ((sh_q[7:4] == ID_ARRAY || sh_q[7:4] == ID_CTRL) && sh_q[3:1] == DEV_SEL) begin
                     oe_d  = 1'b1;
                     ccr_d = (sh_q[7:4] == ID_CTRL);
                     st_d  = sh_q[0] ? tws_pkg::S_RDATA : tws_pkg::S_WAHI;
                  end else begin
                     st_d = tws_pkg::S_IGNORE;
                  end
               end
               tws_pkg::S_WAHI: begin
                  whi_d = sh_q;
                  oe_d  = 1'b1;
                  st_d  = tws_pkg::S_WALO;
               end
               tws_pkg::S_WALO: begin
                  addr_d = {whi_q, sh_q};
                  sr_d   = ccr_q && ({whi_q, sh_q} == `TWS_SR_ADDR);
                  oe_d   = 1'b1;
                  st_d   = tws_pkg::S_WDATA;
               end
               tws_pkg::S_WDATA: begin
                  if (sr_q) begin
                     oe_d = (cnt_q == 7'h00);
                     if (cnt_q == 7'h00) begin
                        srv_d = sh_q;
                        cnt_d = 7'h01;
                     end
                  end else if (wel_q) begin
                     oe_d         = 1'b1;
                     buf_we       = 1'b1;
                     pval_d[lane] = 1'b1;
                     cnt_d        = (cnt_q == 7'h7F) ? cnt_q : cnt_q + 7'h01;
                     addr_d       = nxt(addr_q, ccr_q, 1'b1);
                  end else begin
                     oe_d = 1'b0;
                  end
               end
               default: ack_d = 1'b0;
            endcase
         end
      end
   end

   always_ff @(posedge LINK_CLK) begin
      if (!lnk.rst_n_l) begin
         st_q   <= tws_pkg::S_IDLE;
         bit_q  <= 4'h0;
         sh_q   <= 8'h00;
         ack_q  <= 1'b0;
         mack_q <= 1'b0;
         oe_q   <= 1'b0;
         ccr_q  <= 1'b0;
         sr_q   <= 1'b0;
         srv_q  <= 8'h00;
         whi_q  <= 8'h00;
         addr_q <= `TWS_RST_ADDR;
         cnt_q  <= 7'h00;
         pval_q <= 64'h0;
         wel_q  <= 1'b0;
         register_write_enable_latch_q <= 1'b0;
         req_q  <= 1'b0;
      end else begin
         st_q   <= st_d;
         bit_q  <= bit_d;
         sh_q   <= sh_d;
         ack_q  <= ack_d;
         mack_q <= mack_d;
         oe_q   <= oe_d;
         ccr_q  <= ccr_d;
         sr_q   <= sr_d;
         srv_q  <= srv_d;
         whi_q  <= whi_d;
         addr_q <= addr_d;
         cnt_q  <= cnt_d;
         pval_q <= pval_d;
         wel_q  <= wel_d;
         register_write_enable_latch_q <= register_write_enable_latch_d;
         req_q  <= req_d;
      end
   end

   // The page is copied at the stop; the busy window that follows hides it from the bus.
   always_ff @(posedge LINK_CLK) begin
      if (buf_we) begin
         pbuf[lane] <= sh_q;
      end
      if (commit) begin
         for (int i = 0; i < `TWS_PAGE_LANES; i++) begin
            if (pval_q[i] && ccr_q && i < `TWS_CCR_PAGE) begin
               ccr_mem[{addr_q[5:3], 3'(i)}] <= pbuf[i];
            end else if (pval_q[i] && !ccr_q) begin
               arr_mem[{addr_q[8:6], 6'(i)}] <= pbuf[i];
            end
         end
      end
   end

   assign lnk.req_tgl                 = req_q;
   assign SDA_O                       = 1'b0;
   assign SDA_OE                      = oe_q;
   assign WRITE_ENABLE_LATCH          = wel_q;
   assign REGISTER_WRITE_ENABLE_LATCH = register_write_enable_latch_q;
endmodule // tws_eeprom_slave

// file: test/tws_eeprom_slave_assertions.sv
// Checker for the two-wire memory slave, bound to its top module.
// Assumes the top module ports and its NVW_CYCLES parameter.
`timescale 1ns/10ps
module tws_eeprom_slave_chk #(
   parameter int NVW_CYCLES = 20
) (
   // Clocks and reset
   input wire logic       CLK_SYS,
   input wire logic       RST_N,
   input wire logic       LINK_CLK,
   // Serial pins
   input wire logic       SCL,
   input wire logic       SDA_I,
   input wire logic       SDA_O,
   input wire logic       SDA_OE,
   // Configuration and status
   input wire logic [1:0] PROTECT_SEL,
   input wire logic       NVW_BUSY,
   input wire logic       WRITE_ENABLE_LATCH,
   input wire logic       REGISTER_WRITE_ENABLE_LATCH
);
   logic [31:0] bcnt_q;
   logic [31:0] bcnt_d;
   always_comb begin
      bcnt_d = NVW_BUSY ? bcnt_q + 32'h1 : 32'h0;
   end
   always_ff @(posedge CLK_SYS) begin
      bcnt_q <= RST_N ? bcnt_d : 32'h0;
   end
   a_busy_length: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      $fell(NVW_BUSY) |-> (bcnt_q >= NVW_CYCLES - 1) && (bcnt_q <= NVW_CYCLES + 1))
      else $error("busy interval length wrong");
   a_busy_steady: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      $rose(NVW_BUSY) |=> NVW_BUSY[*8]) else $error("busy dropped early");
   a_quiet_busy: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      NVW_BUSY |-> !SDA_OE) else $error("data driven while busy");
   a_sda_low_only: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      SDA_O == 1'b0) else $error("data output not low");
   a_register_write_enable_latch_with_wel: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      REGISTER_WRITE_ENABLE_LATCH |-> WRITE_ENABLE_LATCH) else $error("register latch without write latch");
   a_register_write_enable_latch_rise_wel: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      $rose(REGISTER_WRITE_ENABLE_LATCH) |-> $past(WRITE_ENABLE_LATCH)) else $error("register latch set too soon");
   a_oe_hold_high: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      SCL[*6] |-> $stable(SDA_OE)) else $error("data changed while clock high");
   a_reset_clear: assert property (@(posedge CLK_SYS)
      (!RST_N)[*3] |-> !NVW_BUSY && !WRITE_ENABLE_LATCH && !REGISTER_WRITE_ENABLE_LATCH && !SDA_OE)
      else $error("state not cleared by reset");
   c_busy: cover property (@(posedge CLK_SYS) $rose(NVW_BUSY));
   c_register_write_enable_latch_set: cover property (@(posedge LINK_CLK) $rose(REGISTER_WRITE_ENABLE_LATCH));
   c_register_write_enable_latch_clr: cover property (@(posedge LINK_CLK) $fell(REGISTER_WRITE_ENABLE_LATCH));
   c_ack: cover property (@(posedge LINK_CLK) $rose(SDA_OE));
endmodule // tws_eeprom_slave_chk
bind tws_eeprom_slave tws_eeprom_slave_chk #(.NVW_CYCLES(NVW_CYCLES)) chk_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
   .LINK_CLK(LINK_CLK), .SCL(SCL), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .PROTECT_SEL(PROTECT_SEL),
   .NVW_BUSY(NVW_BUSY), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
   .REGISTER_WRITE_ENABLE_LATCH(REGISTER_WRITE_ENABLE_LATCH));

// file: test/tws_host_bfm.sv
// Bus master model that bit-bangs the serial clock and pulls the shared data wire.
// Assumes the bench resolves the wire with a pull-up and feeds the level back on sda.
`timescale 1ns/10ps
module tws_host_bfm (
   // Timing reference
   input  wire logic clk,
   // Bus
   input  wire logic sda,
   output logic      scl,
   output logic      sda_pull
);
   initial begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic q();
      repeat (5) @(negedge clk);
   endtask
   // Data moves a quarter bit after the clock falls, so it is never mistaken for start or stop.
   task automatic bit_x(input logic b, output logic r);
      q();
      sda_pull = !b;
      q();
      scl = 1'b1;
      q();
      q();
      r   = sda;
      scl = 1'b0;
   endtask
   task automatic start();
      if (!scl) begin
         q();
         sda_pull = 1'b0;
         q();
         scl = 1'b1;
      end
      q();
      sda_pull = 1'b1;
      q();
      scl = 1'b0;
   endtask
   task automatic stop();
      q();
      sda_pull = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_pull = 1'b0;
      q();
   endtask
   task automatic wr(input logic [7:0] b, input int n, output logic ack);
      logic r;
      for (int i = 0; i < n; i++) begin
         bit_x(b[7-i], r);
      end
      ack = 1'b0;
      if (n == 8) begin
         bit_x(1'b1, r);
         ack = !r;
      end
   endtask
   task automatic rd(input logic ackm, output logic [7:0] d);
      logic r;
      for (int i = 0; i < 8; i++) begin
         bit_x(1'b1, r);
         d[7-i] = r;
      end
      bit_x(!ackm, r);
   endtask
endmodule // tws_host_bfm

// file: test/tb_tws_eeprom_slave.sv
// Self-checking bench for the two-wire memory slave, with a bus master model.
// Assumes the slave bytes follow the identifier and select values passed to the design.
`timescale 1ns/10ps
module tb_tws_eeprom_slave;
   localparam int         NVW = 400;
   localparam logic [7:0] AW  = 8'h54;
   localparam logic [7:0] AR  = 8'h55;
   localparam logic [7:0] CW  = 8'h64;
   localparam logic [7:0] CR  = 8'h65;
   logic       clk_sys, link_clk, rst_n, scl, sda, sda_pull, sda_o, sda_oe, busy, write_enable_latch, register_write_enable_latch;
   logic [1:0] prot;
   int         miscompares, n_checks, cyc;
   assign sda = !(sda_pull || (sda_oe && !sda_o));
   tws_eeprom_slave #(.NVW_CYCLES(NVW), .ID_ARRAY(4'h5), .ID_CTRL(4'h6), .DEV_SEL(3'h2)) dut_u (
      .CLK_SYS(clk_sys), .RST_N(rst_n), .LINK_CLK(link_clk), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o),
      .SDA_OE(sda_oe), .PROTECT_SEL(prot), .NVW_BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch),
      .REGISTER_WRITE_ENABLE_LATCH(register_write_enable_latch));
   tws_host_bfm bfm_u (.clk(clk_sys), .sda(sda), .scl(scl), .sda_pull(sda_pull));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      link_clk = 1'b0;
      #1.7;
      forever #3 link_clk = ~link_clk;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 80000) begin
         miscompares++;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
         miscompares++;
      end
   endtask
   task automatic wb(input logic [7:0] b, input logic e);
      logic a;
      bfm_u.wr(b, 8, a);
      chk("ack", a, e);
   endtask
   task automatic rdb(input logic [7:0] e, input logic ackm);
      logic [7:0] d;
      bfm_u.rd(ackm, d);
      chk("read data", d, e);
   endtask
   task automatic wa(input logic [7:0] slv, input logic [15:0] ad);
      bfm_u.start();
      wb(slv, 1'b1);
      wb(ad[15:8], 1'b1);
      wb(ad[7:0], 1'b1);
   endtask
   // A control slave byte is refused while busy; array polls retry until acknowledged.
   task automatic poll();
      logic a;
      int   n;
      repeat (10) @(negedge clk_sys);
      chk("busy", busy, 1'b1);
      bfm_u.start();
      bfm_u.wr(CW, 8, a);
      bfm_u.stop();
      chk("ctrl ack busy", a, 1'b0);
      n = 0;
      a = 1'b0;
      while (!a && n < 50) begin
         bfm_u.start();
         bfm_u.wr(AW, 8, a);
         bfm_u.stop();
         n++;
      end
      chk("poll ack", a, 1'b1);
      chk("poll refused", n > 1, 1'b1);
   endtask
   task automatic rrd(input logic [7:0] slw, input logic [7:0] slr, input logic [15:0] ad);
      wa(slw, ad);
      bfm_u.start();
      wb(slr, 1'b1);
   endtask
   task automatic t_slave();
      bfm_u.start();
      wb(8'h56, 1'b0);
      bfm_u.stop();
      bfm_u.start();
      wb(8'h74, 1'b0);
      bfm_u.stop();
      $display("test slave done");
   endtask
   task automatic t_latch();
      wa(AW, 16'h0010);
      wb(8'h11, 1'b0);
      bfm_u.stop();
      wa(CW, 16'h003F);
      wb(8'h02, 1'b1);
      bfm_u.stop();
      chk("wel", write_enable_latch, 1'b1);
      wa(CW, 16'h003F);
      wb(8'h06, 1'b1);
      wb(8'h06, 1'b0);
      bfm_u.stop();
      chk("register_write_enable_latch", register_write_enable_latch, 1'b1);
      rrd(CW, CR, 16'h003F);
      rdb(8'h06, 1'b0);
      bfm_u.stop();
      $display("test latch done");
   endtask
   task automatic t_ctrl();
      wa(CW, 16'h0000);
      wb(8'h3C, 1'b1);
      wb(8'hC3, 1'b1);
      bfm_u.stop();
      poll();
      chk("register_write_enable_latch after write", register_write_enable_latch, 1'b0);
      chk("wel after write", write_enable_latch, 1'b1);
      wa(CW, 16'h0000);
      wb(8'h99, 1'b1);
      bfm_u.stop();
      repeat (20) @(negedge clk_sys);
      chk("busy locked", busy, 1'b0);
      rrd(CW, CR, 16'h0000);
      rdb(8'h3C, 1'b1);
      rdb(8'hC3, 1'b0);
      bfm_u.stop();
      $display("test ctrl done");
   endtask
   // 65 bytes from 0x0BE wrap within page 0x080 and the last overwrites the first.
   task automatic t_page();
      wa(AW, 16'h00BE);
      for (int k = 0; k < 65; k++) begin
         wb(8'h10 + 8'(k), 1'b1);
      end
      bfm_u.stop();
      poll();
      rrd(AW, AR, 16'h00BE);
      rdb(8'h50, 1'b1);
      rdb(8'h11, 1'b0);
      bfm_u.stop();
      rrd(AW, AR, 16'h0080);
      rdb(8'h12, 1'b0);
      bfm_u.stop();
      bfm_u.start();
      wb(AR, 1'b1);
      rdb(8'h13, 1'b0);
      bfm_u.stop();
      $display("test page done");
   endtask
   task automatic t_prot();
      logic a;
      wa(AW, 16'h01FF);
      wb(8'hA5, 1'b1);
      bfm_u.stop();
      poll();
      wa(AW, 16'h0000);
      wb(8'h5A, 1'b1);
      bfm_u.stop();
      poll();
      prot = 2'h3;
      wa(AW, 16'h0000);
      wb(8'hC3, 1'b1);
      bfm_u.stop();
      repeat (20) @(negedge clk_sys);
      chk("busy protected", busy, 1'b0);
      prot = 2'h0;
      wa(AW, 16'h0000);
      bfm_u.wr(8'hE7, 4, a);
      bfm_u.stop();
      repeat (20) @(negedge clk_sys);
      chk("busy aborted", busy, 1'b0);
      // A full acknowledged byte followed by a stop in mid byte must still write nothing.
      wa(AW, 16'h0000);
      wb(8'h77, 1'b1);
      bfm_u.wr(8'hE7, 4, a);
      bfm_u.stop();
      repeat (20) @(negedge clk_sys);
      chk("busy mid byte", busy, 1'b0);
      wa(AW, 16'h01FF);
      bfm_u.stop();
      bfm_u.start();
      wb(AR, 1'b1);
      rdb(8'hA5, 1'b1);
      rdb(8'h5A, 1'b0);
      bfm_u.stop();
      wa(CW, 16'h003F);
      wb(8'h00, 1'b1);
      bfm_u.stop();
      chk("wel cleared", write_enable_latch, 1'b0);
      chk("register_write_enable_latch cleared", register_write_enable_latch, 1'b0);
      $display("test protect done");
   endtask
   initial begin
      rst_n       = 1'b0;
      prot        = 2'h0;
      miscompares = 0;
      n_checks    = 0;
      cyc         = 0;
      repeat (4) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (10) @(negedge clk_sys);
      t_slave();
      t_latch();
      t_ctrl();
      t_page();
      t_prot();
      stop_test();
   end
endmodule // tb_tws_eeprom_slave
